// ---- inc/bridge_hdr_pkg.sv ----
// constants and types for the upper bridge configuration header
`default_nettype none
package bridge_hdr_pkg;
	// byte addresses of the configuration dwords
	localparam logic [7:0] OFS_PF_BASE_HI = 8'h28;
	localparam logic [7:0] OFS_PF_LIMIT_HI = 8'h2C;
	localparam logic [7:0] OFS_IO_HI = 8'h30;
	localparam logic [7:0] OFS_CAP_PTR = 8'h34;
	localparam logic [7:0] OFS_ROM_BASE = 8'h38;
	localparam logic [7:0] OFS_IRQ_BRG = 8'h3C;
	// reset and fixed read values
	localparam logic [31:0] RST_PF_HI = 32'h0000_0000;
	localparam logic [15:0] RST_IO_HI = 16'h0000;
	localparam logic [7:0] RST_IRQ_LINE = 8'h00;
	localparam logic [7:0] IRQ_PIN_VAL = 8'h01;
	localparam logic [7:0] CAP_PTR_NORMAL = 8'h80;
	localparam logic [7:0] CAP_PTR_LEGACY = 8'h90;
	localparam logic [31:0] ROM_BASE_VAL = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
	// bridge control: five stored bits, dword bit = BC_LSB + index
	localparam int BC_LSB = 16;
	localparam int BC_WIDTH = 5;
	localparam logic [BC_WIDTH-1:0] RST_BRG_CTL = 5'h00;
	localparam int BC_PERR = 0;
	localparam int BC_SERR = 1;
	localparam int BC_ISA = 2;
	localparam int BC_VGA = 3;
	localparam int BC_VGA16 = 4;
	// field positions inside the shared dwords
	localparam int IO_BASE_LSB = 0;
	localparam int IO_LIMIT_LSB = 16;
	localparam int IRQ_LINE_LSB = 0;
	localparam int IRQ_PIN_LSB = 8;
	// window granularity fill bits
	localparam logic [11:0] IO_GRAN_LO = 12'h000;
	localparam logic [11:0] IO_GRAN_HI = 12'hFFF;
	localparam logic [19:0] MEM_GRAN_LO = 20'h00000;
	localparam logic [19:0] MEM_GRAN_HI = 20'hFFFFF;
	// legacy display ranges and the 64KB legacy alias region
	localparam logic [9:0] VGA_IO_MONO_LO = 10'h3B0;
	localparam logic [9:0] VGA_IO_MONO_HI = 10'h3BB;
	localparam logic [9:0] VGA_IO_COLOR_LO = 10'h3C0;
	localparam logic [9:0] VGA_IO_COLOR_HI = 10'h3DF;
	localparam logic [19:0] VGA_MEM_LO = 20'hA0000;
	localparam logic [19:0] VGA_MEM_HI = 20'hBFFFF;
	localparam logic [15:0] ISA_UPPER_ZERO = 16'h0000;
	localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;
	localparam logic [5:0] VGA16_UPPER_ZERO = 6'h00;
	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;
endpackage
`default_nettype wire

// ---- inc/route_if.sv ----
// configuration and address carrier between the register bank and the route decoder
`default_nettype none
interface route_if;
	logic io_enable;
	logic mem_enable;
	logic [31:0] io_base;
	logic [31:0] io_limit;
	logic [63:0] pf_base;
	logic [63:0] pf_limit;
	logic [4:0] brg_ctl;
	logic [31:0] io_addr;
	logic [63:0] mem_addr;
	logic io_down;
	logic mem_down;
	modport owner (
		output io_enable, mem_enable, io_base, io_limit, pf_base, pf_limit, brg_ctl, io_addr, mem_addr,
		input io_down, mem_down
	);
	modport decoder (
		input io_enable, mem_enable, io_base, io_limit, pf_base, pf_limit, brg_ctl, io_addr, mem_addr,
		output io_down, mem_down
	);
endinterface
`default_nettype wire

// ---- src/legacy_route_decode.sv ----
// window and legacy-display routing decision for one I/O and one memory address
`default_nettype none
module legacy_route_decode
	import bridge_hdr_pkg::*;
(
	route_if.decoder rt
);
	logic io_in_win;
	logic isa_hole;
	logic vga_io_range;
	logic vga_io_hit;
	logic pf_in_win;
	logic vga_mem_hit;

	// 10-bit decode aliases the display ports through all of I/O space
	function automatic logic vga_port(input logic [9:0] a);
		vga_port = (a >= VGA_IO_MONO_LO && a <= VGA_IO_MONO_HI) ||
			(a >= VGA_IO_COLOR_LO && a <= VGA_IO_COLOR_HI);
	endfunction

	always_comb begin
		io_in_win = rt.io_enable && rt.io_addr >= rt.io_base && rt.io_addr <= rt.io_limit;
		// top 768 bytes of each 1KB block in the first 64KB go upstream
		isa_hole = rt.brg_ctl[BC_ISA] && rt.io_addr[31:16] == ISA_UPPER_ZERO &&
			rt.io_addr[9:8] != ISA_LOW_QUARTER;
		// 16-bit decode also demands zero in address bits 31:10
		vga_io_range = vga_port(rt.io_addr[9:0]) &&
			(!rt.brg_ctl[BC_VGA16] || (rt.io_addr[15:10] == VGA16_UPPER_ZERO &&
			rt.io_addr[31:16] == ISA_UPPER_ZERO));
		// display forwarding wins over the alias hole
		vga_io_hit = rt.brg_ctl[BC_VGA] && rt.io_enable && vga_io_range;
		rt.io_down = vga_io_hit || (io_in_win && !isa_hole);
		// full 64-bit window built from the upper halves
		pf_in_win = rt.mem_enable && rt.mem_addr >= rt.pf_base && rt.mem_addr <= rt.pf_limit;
		vga_mem_hit = rt.brg_ctl[BC_VGA] && rt.mem_enable && rt.mem_addr[63:20] == 44'h000_0000_0000 &&
			rt.mem_addr[19:0] >= VGA_MEM_LO && rt.mem_addr[19:0] <= VGA_MEM_HI;
		rt.mem_down = pf_in_win || vga_mem_hit;
	end
endmodule
`default_nettype wire

// ---- src/bridge_config_header_upper.sv ----
// upper type-1 configuration dwords 28h..3Ch with Avalon-MM access and routing outputs
//
// The Avalon-MM register port was decided locally.
`default_nettype none
// Functional notes
// - a 32-bit writable register holds bits 63:32 of the prefetchable limit and resets to zero.
// - bits 15:0 of dword 30h are writable, give I/O base bits 31:16 and reset to zero.
// - bits 31:16 of dword 30h are writable, give I/O limit bits 31:16 and reset to zero.
// - the capability pointer reads 80h, or 90h in legacy mode, with bits 31:8 zero.
// - no option ROM exists, so dword 38h is read-only and reads zero.
// - an 8-bit writable interrupt routing byte resets to 00h and is set by init software.
// - the interrupt pin byte reads 01h, meaning interrupt line A.
// - control bit 16 enables acting on secondary parity errors and resets to 0.
// - control bit 17 gates forwarding of secondary system errors upstream and resets to 0.
// - with bit 18 set, in-window I/O in the first 64KB top 768 bytes of each 1KB goes upstream, except display ports forwarded by bit 19.
// - with bit 19 set, legacy display memory and I/O always go downstream if enabled.
// - bit 20 selects 10-bit (clear) or 16-bit (set) decode of display I/O and resets to 0.
// - a 32-bit writable register holds bits 63:32 of the prefetchable base and resets to zero.
module bridge_config_header_upper
	import bridge_hdr_pkg::*;
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic legacy_mode_in,
	input wire logic io_enable_in,
	input wire logic mem_enable_in,
	input wire logic [3:0] io_base_lo_in,
	input wire logic [3:0] io_limit_lo_in,
	input wire logic [11:0] pf_base_lo_in,
	input wire logic [11:0] pf_limit_lo_in,
	input wire logic io_req_in,
	input wire logic [31:0] io_addr_in,
	input wire logic mem_req_in,
	input wire logic [63:0] mem_addr_in,
	output logic io_route_valid_out,
	output logic io_forward_down_out,
	output logic mem_route_valid_out,
	output logic mem_forward_down_out,
	input wire logic sec_parity_err_in,
	output logic parity_err_report_out,
	input wire logic sec_serr_n_in,
	output logic syserr_msg_req_out,
	output logic [7:0] irq_line_out,
	output logic [4:0] bridge_ctl_out
);
	bus_state_t state_ff;
	bus_state_t nxt_state;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] pf_base_hi_ff;
	logic [31:0] pf_limit_hi_ff;
	logic [15:0] io_base_hi_ff;
	logic [15:0] io_limit_hi_ff;
	logic [7:0] irq_line_ff;
	logic [BC_WIDTH-1:0] brg_ctl_ff;
	logic legacy_meta_ff;
	logic legacy_sync_ff;
	logic serr_meta_ff;
	logic serr_sync_ff;
	logic serr_prev_ff;
	logic io_valid_ff;
	logic io_down_ff;
	logic mem_valid_ff;
	logic mem_down_ff;
	logic perr_ff;
	logic syserr_ff;
	logic wr_take;
	logic [31:0] io_dword;
	logic [31:0] irq_dword;
	logic [31:0] cur_dword;

	route_if rt ();

	// a request is answered in the cycle after it is first seen
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr[7:2] == ofs[7:2];
	endfunction

	// strap and secondary error pin cross in through two flops each
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			legacy_meta_ff <= 1'b0;
			legacy_sync_ff <= 1'b0;
		end else begin
			legacy_meta_ff <= legacy_mode_in;
			legacy_sync_ff <= legacy_meta_ff;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			serr_meta_ff <= 1'b1;
			serr_sync_ff <= 1'b1;
			serr_prev_ff <= 1'b1;
		end else begin
			serr_meta_ff <= sec_serr_n_in;
			serr_sync_ff <= serr_meta_ff;
			serr_prev_ff <= serr_sync_ff;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			BUS_IDLE: begin
				if (avs_read_in || avs_write_in) begin
					nxt_state = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				nxt_state = BUS_IDLE;
			end
			default: begin
				nxt_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			state_ff <= BUS_IDLE;
			wait_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			wait_ff <= (nxt_state != BUS_ANSWER);
		end
	end

	// the write lands on the edge where waitrequest is seen low
	assign wr_take = avs_write_in && state_ff == BUS_ANSWER;

	assign io_dword = {io_limit_hi_ff, io_base_hi_ff};
	assign cur_dword = merge_bytes(io_dword, avs_writedata_in, avs_byteenable_in);
	assign irq_dword = {{(16 - BC_WIDTH){1'b0}}, brg_ctl_ff, IRQ_PIN_VAL, irq_line_ff};

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pf_base_hi_ff <= RST_PF_HI;
		end else if (wr_take && word_hit(avs_address_in, OFS_PF_BASE_HI)) begin
			pf_base_hi_ff <= merge_bytes(pf_base_hi_ff, avs_writedata_in, avs_byteenable_in);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pf_limit_hi_ff <= RST_PF_HI;
		end else if (wr_take && word_hit(avs_address_in, OFS_PF_LIMIT_HI)) begin
			pf_limit_hi_ff <= merge_bytes(pf_limit_hi_ff, avs_writedata_in, avs_byteenable_in);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			io_base_hi_ff <= RST_IO_HI;
			io_limit_hi_ff <= RST_IO_HI;
		end else if (wr_take && word_hit(avs_address_in, OFS_IO_HI)) begin
			io_base_hi_ff <= cur_dword[IO_BASE_LSB +: 16];
			io_limit_hi_ff <= cur_dword[IO_LIMIT_LSB +: 16];
		end
	end

	// only the routing byte and the five control bits take data here
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			irq_line_ff <= RST_IRQ_LINE;
			brg_ctl_ff <= RST_BRG_CTL;
		end else if (wr_take && word_hit(avs_address_in, OFS_IRQ_BRG)) begin
			if (avs_byteenable_in[0]) begin
				irq_line_ff <= avs_writedata_in[IRQ_LINE_LSB +: 8];
			end
			if (avs_byteenable_in[2]) begin
				brg_ctl_ff <= avs_writedata_in[BC_LSB +: BC_WIDTH];
			end
		end
	end

	// cap pointer, rom base and pin byte are constants, so writes fall through
	always_comb begin
		if (word_hit(avs_address_in, OFS_PF_BASE_HI)) begin
			nxt_rdata = pf_base_hi_ff;
		end else if (word_hit(avs_address_in, OFS_PF_LIMIT_HI)) begin
			nxt_rdata = pf_limit_hi_ff;
		end else if (word_hit(avs_address_in, OFS_IO_HI)) begin
			nxt_rdata = io_dword;
		end else if (word_hit(avs_address_in, OFS_CAP_PTR)) begin
			nxt_rdata = {24'h00_0000, legacy_sync_ff ? CAP_PTR_LEGACY : CAP_PTR_NORMAL};
		end else if (word_hit(avs_address_in, OFS_ROM_BASE)) begin
			nxt_rdata = ROM_BASE_VAL;
		end else if (word_hit(avs_address_in, OFS_IRQ_BRG)) begin
			nxt_rdata = irq_dword;
		end else begin
			nxt_rdata = UNMAPPED_VAL;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			rdata_ff <= UNMAPPED_VAL;
		end else if (state_ff == BUS_IDLE && avs_read_in) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// full windows; lower bits come from the dwords held elsewhere in the core
	always_comb begin
		rt.io_enable = io_enable_in;
		rt.mem_enable = mem_enable_in;
		rt.io_base = {io_base_hi_ff, io_base_lo_in, IO_GRAN_LO};
		rt.io_limit = {io_limit_hi_ff, io_limit_lo_in, IO_GRAN_HI};
		rt.pf_base = {pf_base_hi_ff, pf_base_lo_in, MEM_GRAN_LO};
		rt.pf_limit = {pf_limit_hi_ff, pf_limit_lo_in, MEM_GRAN_HI};
		rt.brg_ctl = brg_ctl_ff;
		rt.io_addr = io_addr_in;
		rt.mem_addr = mem_addr_in;
	end

	legacy_route_decode u_decode (
		.rt(rt.decoder)
	);

	// one-cycle decision latency keeps the outputs registered
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			io_valid_ff <= 1'b0;
			io_down_ff <= 1'b0;
		end else begin
			io_valid_ff <= io_req_in;
			io_down_ff <= io_req_in && rt.io_down;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			mem_valid_ff <= 1'b0;
			mem_down_ff <= 1'b0;
		end else begin
			mem_valid_ff <= mem_req_in;
			mem_down_ff <= mem_req_in && rt.mem_down;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			perr_ff <= 1'b0;
		end else begin
			perr_ff <= sec_parity_err_in && brg_ctl_ff[BC_PERR];
		end
	end

	// falling edge of the synced pin; a held-low pin gives one message only
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			syserr_ff <= 1'b0;
		end else begin
			syserr_ff <= serr_prev_ff && !serr_sync_ff && brg_ctl_ff[BC_SERR];
		end
	end

	assign avs_readdata_out = rdata_ff;
	assign avs_waitrequest_out = wait_ff;
	assign io_route_valid_out = io_valid_ff;
	assign io_forward_down_out = io_down_ff;
	assign mem_route_valid_out = mem_valid_ff;
	assign mem_forward_down_out = mem_down_ff;
	assign parity_err_report_out = perr_ff;
	assign syserr_msg_req_out = syserr_ff;
	assign irq_line_out = irq_line_ff;
	assign bridge_ctl_out = brg_ctl_ff;
endmodule
`default_nettype wire

// ---- bench/sec_bus_model.sv ----
// secondary bus stand-in raising system error and parity events
`default_nettype none
module sec_bus_model (
	input wire logic mclk_in,
	input wire logic serr_go_in,
	input wire logic perr_go_in,
	output logic sec_serr_n_out,
	output var logic sec_parity_err_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] hold_ff = 3'h0;
	initial sec_parity_err_out = 1'b0;
	// pin has a pull-up, so a released pin reads high
	assign sec_serr_n_out = (hold_ff == 3'h0);
	always @(posedge mclk_in) begin
		hold_ff <= serr_go_in ? 3'h4 : (hold_ff != 3'h0 ? hold_ff - 3'h1 : 3'h0);
		sec_parity_err_out <= perr_go_in;
	end
endmodule
`default_nettype wire

// ---- bench/bridge_hdr_props.sv ----
// concurrent checks on the upper bridge configuration ports
`default_nettype none
module bridge_hdr_props
	import bridge_hdr_pkg::*;
(
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic avs_waitrequest_out,
	input wire logic io_req_in,
	input wire logic io_route_valid_out,
	input wire logic io_forward_down_out,
	input wire logic mem_req_in,
	input wire logic mem_route_valid_out,
	input wire logic mem_forward_down_out,
	input wire logic sec_parity_err_in,
	input wire logic parity_err_report_out,
	input wire logic syserr_msg_req_out,
	input wire logic [7:0] irq_line_out,
	input wire logic [4:0] bridge_ctl_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wr_hit, perr_gate, serr_en;
	// a write lands only at the edge where waitrequest is low
	assign wr_hit = avs_write_in && !avs_waitrequest_out && avs_address_in[7:2] == OFS_IRQ_BRG[7:2];
	assign perr_gate = sec_parity_err_in && bridge_ctl_out[BC_PERR];
	assign serr_en = bridge_ctl_out[BC_SERR];
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);
	a_wait_one_low: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("waitrequest not low for one cycle");
	a_irq_byte_write: assert property (wr_hit && avs_byteenable_in[0]
		|=> irq_line_out == $past(avs_writedata_in[7:0])) else $error("routing byte not written");
	a_ctl_byte_write: assert property (wr_hit && avs_byteenable_in[2]
		|=> bridge_ctl_out == $past(avs_writedata_in[20:16])) else $error("control bits not written");
	a_ctl_hold: assert property (!wr_hit
		|=> $stable(bridge_ctl_out) && $stable(irq_line_out)) else $error("fields changed without write");
	a_parity_gate: assert property (1'b1
		|=> parity_err_report_out == $past(perr_gate)) else $error("parity report wrong");
	a_serr_pulse: assert property (syserr_msg_req_out
		|-> $past(serr_en) ##1 !syserr_msg_req_out) else $error("system error request wrong");
	a_io_follow: assert property (1'b1
		|=> io_route_valid_out == $past(io_req_in)) else $error("io valid does not follow request");
	a_mem_follow: assert property (1'b1
		|=> mem_route_valid_out == $past(mem_req_in)) else $error("mem valid does not follow request");
	a_down_needs_req: assert property ((io_forward_down_out |-> io_route_valid_out)
		and (mem_forward_down_out |-> mem_route_valid_out)) else $error("forward without request");
	c_read_done: cover property (avs_read_in && !avs_waitrequest_out);
	c_syserr: cover property (syserr_msg_req_out);
	c_io_down: cover property (io_forward_down_out);
endmodule
bind bridge_config_header_upper bridge_hdr_props bridge_hdr_props_i (.*);
`default_nettype wire

// ---- bench/bridge_config_header_upper_tb_top.sv ----
// self-checking bench for the upper bridge configuration dwords
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, s); end end
module bridge_config_header_upper_tb_top
	import bridge_hdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_in = 1'b0, srst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0, legacy_mode_in = 1'b0;
	logic io_enable_in = 1'b1, mem_enable_in = 1'b1, io_req_in = 1'b0, mem_req_in = 1'b0;
	logic sec_parity_err_in, sec_serr_n_in, serr_go = 1'b0, perr_go = 1'b0;
	logic [7:0] avs_address_in = 8'h00;
	logic [3:0] avs_byteenable_in = 4'h0, io_base_lo_in = 4'h0, io_limit_lo_in = 4'h0;
	logic [11:0] pf_base_lo_in = 12'h001, pf_limit_lo_in = 12'h001;
	logic [31:0] avs_writedata_in = 32'h0, io_addr_in = 32'h0, avs_readdata_out, q;
	logic [63:0] mem_addr_in = 64'h0;
	logic avs_waitrequest_out, io_route_valid_out, io_forward_down_out, mem_route_valid_out, mem_forward_down_out;
	logic parity_err_report_out, syserr_msg_req_out;
	logic [7:0] irq_line_out;
	logic [4:0] bridge_ctl_out;
	int n_errors = 0, tests_run = 0, cyc = 0;
	bridge_config_header_upper bridge_config_header_upper_i (.*);
	sec_bus_model sec_bus_model_i (.mclk_in, .serr_go_in(serr_go), .perr_go_in(perr_go),
		.sec_serr_n_out(sec_serr_n_in), .sec_parity_err_out(sec_parity_err_in));
	always #2.5 mclk_in = ~mclk_in;
	// whole run needs well under a thousand cycles
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge mclk_in);
		avs_address_in <= a;
		avs_byteenable_in <= be;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 4'h0, 32'h0);
		`CHK("readdata", e, q)
	endtask
	task automatic ctl(input logic [4:0] b);
		bus(1'b1, OFS_IRQ_BRG, 4'h4, {11'h0, b, 16'h0});
	endtask
	task automatic route(input logic m, input logic [63:0] a, input logic e);
		logic [1:0] got;
		@(posedge mclk_in);
		mem_req_in <= m;
		io_req_in <= !m;
		mem_addr_in <= a;
		io_addr_in <= a[31:0];
		@(posedge mclk_in);
		mem_req_in <= 1'b0;
		io_req_in <= 1'b0;
		#1;
		got = m ? {mem_route_valid_out, mem_forward_down_out} : {io_route_valid_out, io_forward_down_out};
		`CHK("route", {1'b1, e}, got)
	endtask
	task automatic t_regs();
		logic [7:0] ad[7];
		logic [31:0] ones[7];
		ad = '{OFS_PF_BASE_HI, OFS_PF_LIMIT_HI, OFS_IO_HI, OFS_CAP_PTR, OFS_ROM_BASE, OFS_IRQ_BRG, 8'h40};
		ones = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h80, 32'h0, 32'h001F01FF, 32'h0};
		for (int i = 0; i < 7; i++) begin
			rd(ad[i], i == 3 ? 32'h80 : (i == 5 ? 32'h100 : 32'h0));
			bus(1'b1, ad[i], 4'hF, 32'hFFFFFFFF);
			rd(ad[i], ones[i]);
		end
		`CHK("irq_line", 8'hFF, irq_line_out)
		`CHK("bridge_ctl", 5'h1F, bridge_ctl_out)
		bus(1'b1, OFS_PF_LIMIT_HI, 4'h5, 32'h12345678);
		rd(OFS_PF_LIMIT_HI, 32'hFF34FF78);
	endtask
	task automatic t_legacy();
		legacy_mode_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		rd(OFS_CAP_PTR, 32'h90);
		legacy_mode_in <= 1'b0;
	endtask
	task automatic t_errs();
		logic [3:0] n;
		for (int k = 0; k < 2; k++) begin
			ctl(k ? 5'h03 : 5'h00);
			@(posedge mclk_in);
			perr_go <= 1'b1;
			serr_go <= 1'b1;
			@(posedge mclk_in);
			perr_go <= 1'b0;
			serr_go <= 1'b0;
			n = 4'h0;
			repeat (10) begin
				@(posedge mclk_in);
				#1;
				n = n + parity_err_report_out + syserr_msg_req_out;
			end
			`CHK("err_events", k ? 4'h2 : 4'h0, n)
		end
	endtask
	task automatic t_route();
		logic [4:0] c[13];
		logic [63:0] a[13];
		logic m[13];
		logic e[13];
		c = '{5'h00, 5'h04, 5'h04, 5'h04, 5'h0C, 5'h08, 5'h18, 5'h18, 5'h00, 5'h08, 5'h00, 5'h00, 5'h00};
		a = '{64'h100, 64'h100, 64'hFF, 64'h3C0, 64'h3C0, 64'h13C0, 64'h13C0, 64'h3B0, 64'hA0000, 64'hA0000,
			64'h150000, 64'h1_0015_0000, 64'h250000};
		m = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
		e = '{1, 0, 1, 0, 1, 1, 0, 1, 0, 1, 1, 0, 0};
		bus(1'b1, OFS_PF_BASE_HI, 4'hF, 32'h0);
		bus(1'b1, OFS_PF_LIMIT_HI, 4'hF, 32'h0);
		bus(1'b1, OFS_IO_HI, 4'hF, 32'h0);
		for (int i = 0; i < 13; i++) begin
			ctl(c[i]);
			route(m[i], a[i], e[i]);
		end
		// display forwarding still obeys the command enables
		ctl(5'h08);
		io_enable_in <= 1'b0;
		mem_enable_in <= 1'b0;
		route(1'b0, 64'h3C0, 1'b0);
		route(1'b1, 64'hA0000, 1'b0);
		@(posedge mclk_in);
		io_enable_in <= 1'b1;
		mem_enable_in <= 1'b1;
		bus(1'b1, OFS_PF_LIMIT_HI, 4'hF, 32'h1);
		route(1'b1, 64'h1_0015_0000, 1'b1);
		bus(1'b1, OFS_IO_HI, 4'hF, 32'h0001_0000);
		route(1'b0, 64'h10100, 1'b1);
		bus(1'b1, OFS_IO_HI, 4'h3, 32'h0000_0001);
		route(1'b0, 64'h100, 1'b0);
	endtask
	initial begin
		repeat (3) @(posedge mclk_in);
		srst_in <= 1'b0;
		t_regs();
		t_legacy();
		t_errs();
		t_route();
		complete_run();
	end
endmodule
`default_nettype wire
